// ===== asb_cfg.svh
`ifndef ASB_CFG_SVH
`define ASB_CFG_SVH
// register byte offsets
`define ASB_OFS_DATA 12'h000
`define ASB_OFS_STATUS 12'h004
`define ASB_OFS_COMMAND 12'h008
`define ASB_OFS_CONTROL 12'h00c
// reset values
`define ASB_CONTROL_RST 8'h00
`define ASB_COMMAND_RST 8'h00
`define ASB_LINE_IDLE 1'b1
// field positions
`define ASB_CMD_ENABLE 0
`define ASB_BAUD_MSB 3
`define ASB_BAUD_LSB 0
// baud-select code for the external clock
`define ASB_BAUD_EXT 4'h0
// receive buffer depth
`define ASB_FIFO_DEPTH 8
// clock rate and external divide ratio
`define ASB_CLK_HZ 100000000
`define ASB_EXT_DIV 16
// internal rates in hundredths of a baud
`define ASB_CB_SCALE 100
`define ASB_CB_1 5000
`define ASB_CB_2 7500
`define ASB_CB_3 10992
`define ASB_CB_4 13458
`define ASB_CB_5 15000
`define ASB_CB_6 30000
`define ASB_CB_7 60000
`define ASB_CB_8 120000
`define ASB_CB_9 180000
`define ASB_CB_10 240000
`define ASB_CB_11 360000
`define ASB_CB_12 480000
`define ASB_CB_13 720000
`define ASB_CB_14 960000
`define ASB_CB_15 1920000
`endif

// ===== asb_pkg.sv
`default_nettype none
package asb_pkg;
  // one received character with its error marks
  typedef struct packed {
    logic parityErr;
    logic framingErr;
    logic [7:0] data;
  } asb_rx_char_t;
  // status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic irq;
    logic dsrLevel;
    logic dcdLevel;
    logic txEmpty;
    logic rxFull;
    logic overrun;
    logic framingErr;
    logic parityErr;
  } asb_status_t;
  // transmit output stage
  typedef enum logic {TX_IDLE, TX_OFFER} asb_tx_state_t;
endpackage
`default_nettype wire

// ===== asb_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "asb_cfg.svh"
module asb_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = `ASB_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem_reg[rdPtr_reg];

  // fill level
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // storage, no reset needed
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end

  // pointers, count and registered flags
  always_ff @(posedge mclk) begin
    if (reset) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (push) wrPtr_reg <= wrPtr_reg + 1'b1;
      if (pop) rdPtr_reg <= rdPtr_reg + 1'b1;
      count_reg <= count_next;
      inReady <= (count_next != CW'(DEPTH));
      outValid <= (count_next != '0);
    end
  end
endmodule
`default_nettype wire

// ===== asb_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "asb_cfg.svh"
module asb_baud_gen #(
  parameter int CLK_HZ = `ASB_CLK_HZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // rate control
  input wire logic enable,
  input wire logic [3:0] baudSelect,
  // external clock, sampled as a level
  input wire logic extClk,
  // one pulse per transmit bit time
  output logic bitTick
);
  logic extPrev_reg;
  logic [3:0] extCount_reg;
  logic [31:0] divCount_reg;
  logic [3:0] selSeen_reg;
  logic extEdge;
  logic [31:0] divLimit;

  // mclk cycles in one bit at an internal rate
  function automatic logic [31:0] cyclesPerBit(input logic [3:0] sel);
    longint centiBaud;
    case (sel)
      4'h1: centiBaud = `ASB_CB_1;
      4'h2: centiBaud = `ASB_CB_2;
      4'h3: centiBaud = `ASB_CB_3;
      4'h4: centiBaud = `ASB_CB_4;
      4'h5: centiBaud = `ASB_CB_5;
      4'h6: centiBaud = `ASB_CB_6;
      4'h7: centiBaud = `ASB_CB_7;
      4'h8: centiBaud = `ASB_CB_8;
      4'h9: centiBaud = `ASB_CB_9;
      4'ha: centiBaud = `ASB_CB_10;
      4'hb: centiBaud = `ASB_CB_11;
      4'hc: centiBaud = `ASB_CB_12;
      4'hd: centiBaud = `ASB_CB_13;
      4'he: centiBaud = `ASB_CB_14;
      default: centiBaud = `ASB_CB_15;
    endcase
    return 32'((longint'(CLK_HZ) * `ASB_CB_SCALE) / centiBaud);
  endfunction

  assign extEdge = extClk & ~extPrev_reg;
  assign divLimit = cyclesPerBit(baudSelect) - 32'h1;

  // rising-edge detect on the external clock, and rate change watch
  always_ff @(posedge mclk) begin
    if (reset) begin
      extPrev_reg <= 1'b0;
      selSeen_reg <= `ASB_BAUD_EXT;
    end else begin
      extPrev_reg <= extClk;
      selSeen_reg <= baudSelect;
    end
  end

  // divider restarts on any rate change or while disabled
  always_ff @(posedge mclk) begin
    if (reset || !enable || baudSelect != selSeen_reg) begin
      extCount_reg <= 4'h0;
      divCount_reg <= 32'h0;
      bitTick <= 1'b0;
    end else if (baudSelect == `ASB_BAUD_EXT) begin
      bitTick <= extEdge && (extCount_reg == 4'(`ASB_EXT_DIV - 1)); // [RL13]
      if (extEdge) begin
        extCount_reg <= extCount_reg + 4'h1;
      end
    end else begin
      bitTick <= (divCount_reg == divLimit); // [RL14]
      if (divCount_reg == divLimit) begin
        divCount_reg <= 32'h0;
      end else begin
        divCount_reg <= divCount_reg + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== asb_serial_status.sv
// Functional notes
// RL1 - status bit 1 shows a framing error on the held character
// RL2 - status bit 2 shows that a receive overrun occurred
// RL3 - parity, framing and overrun flags never raise an interrupt
// RL4 - status bit 3 shows the receive holding register is full
// RL5 - status bit 4 shows the transmit holding register is empty
// RL6 - status bit 5 reads the carrier-detect level, 1 means not detected
// RL7 - status bit 6 reads the data-set-ready level, 1 means not ready
// RL8 - status bit 7 sets on any interrupt, clears on a status read
// RL9 - after a modem interrupt, levels freeze until status is read
// RL10 - status read with a changed held line raises a new interrupt
// RL11 - only command bit 0 low stops modem interrupts, and stops transfers
// RL12 - control bits 3..0 choose the transmit rate
// RL13 - code zero divides the external clock by sixteen
// RL14 - nonzero codes pick internal rates, 1 is 50 and 2 is 75 baud
// RL15 - receive full sets on move into holding, clears on data read
// RL16 - transmit empty sets on move to shifter, clears on data write
// RL17 - any modem line change interrupts while the adapter is enabled
// RL18 - interrupt output low while status bit 7 is set
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "asb_cfg.svh"
module asb_serial_status #(
  parameter int CLK_HZ = `ASB_CLK_HZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,

  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,

  // characters from the receive shifter
  input wire logic rxCharValid,
  input wire asb_pkg::asb_rx_char_t rxChar,
  output logic rxCharReady,

  // characters to the transmit shifter
  output logic txCharValid,
  output logic [7:0] txCharData,
  input wire logic txCharReady,
  output logic txBitTick,

  // external baud clock
  input wire logic extClk,

  // modem lines, active low
  input wire logic dcdN,
  input wire logic dsrN,

  // interrupt to the processor
  output logic irqN
);

  // software-visible registers
  logic [7:0] control_reg;
  logic [7:0] command_reg;
  logic [7:0] rxHold_reg;
  logic [7:0] txHold_reg;

  // status flags
  logic parity_reg;
  logic framing_reg;
  logic overrun_reg;
  logic rxFull_reg;
  logic txEmpty_reg;
  logic irqFlag_reg;
  logic irqFlag_next;

  // modem line capture
  logic dcdHeld_reg;
  logic dsrHeld_reg;
  logic modemLock_reg;
  logic modemChanged;
  logic modemEvent;

  // transmit stage
  asb_pkg::asb_tx_state_t txState_reg;
  logic txMove;

  // receive buffer wires
  logic fifoInValid;
  logic fifoOutValid;
  logic [$bits(asb_pkg::asb_rx_char_t)-1:0] fifoOutData;
  asb_pkg::asb_rx_char_t rxHead;
  logic rxMove;

  // bus decode
  // decodes are single-cycle strobes derived from the apb phases
  logic enable;
  logic rdCapture;
  logic wrCommit;
  logic rdStatus;
  logic rdData;
  logic wrData;
  logic wrCommand;
  logic wrControl;
  asb_pkg::asb_status_t statusNow;

  // widen a byte to a bus word
  function automatic logic [31:0] toWord(input logic [7:0] b);
    return {24'h000000, b};
  endfunction

  // true for an offset that holds a register
  function automatic logic isMapped(input logic [11:0] a);
    return (a == `ASB_OFS_DATA) || (a == `ASB_OFS_STATUS) ||
           (a == `ASB_OFS_COMMAND) || (a == `ASB_OFS_CONTROL);
  endfunction

  // adapter enable from the command register
  // the other command bits are stored but drive nothing here
  assign enable = command_reg[`ASB_CMD_ENABLE];

  // reads act on the capture edge, writes on the completing edge
  // a read side effect must fire once per transfer, so it keys on the
  // access cycle before pready, which appears exactly once
  assign rdCapture = psel & penable & ~pready & ~pwrite;
  assign wrCommit = psel & penable & pready & pwrite;
  assign rdStatus = rdCapture && (paddr == `ASB_OFS_STATUS);
  assign rdData = rdCapture && (paddr == `ASB_OFS_DATA);
  assign wrData = wrCommit && (paddr == `ASB_OFS_DATA);
  assign wrCommand = wrCommit && (paddr == `ASB_OFS_COMMAND);
  assign wrControl = wrCommit && (paddr == `ASB_OFS_CONTROL);

  // status word as software sees it
  // modem bits show the held levels, not the pins
  always_comb begin
    statusNow.irq = irqFlag_reg; // [RL8]
    statusNow.dsrLevel = dsrHeld_reg; // [RL7]
    statusNow.dcdLevel = dcdHeld_reg; // [RL6]
    statusNow.txEmpty = txEmpty_reg; // [RL5]
    statusNow.rxFull = rxFull_reg; // [RL4]
    statusNow.overrun = overrun_reg; // [RL2]
    statusNow.framingErr = framing_reg; // [RL1]
    statusNow.parityErr = parity_reg;
  end

  // apb answer: one wait state, data and error registered
  // unmapped offsets answer with an error and zero data
  // status writes are accepted without error and change nothing
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        pslverr <= ~isMapped(paddr);
        case (paddr)
          `ASB_OFS_DATA: prdata <= toWord(rxHold_reg);
          `ASB_OFS_STATUS: prdata <= toWord(statusNow);
          `ASB_OFS_COMMAND: prdata <= toWord(command_reg);
          `ASB_OFS_CONTROL: prdata <= toWord(control_reg);
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // control and command registers
  // upper control bits are stored only; rate select is bits 3..0
  always_ff @(posedge mclk) begin
    if (reset) begin
      control_reg <= `ASB_CONTROL_RST;
      command_reg <= `ASB_COMMAND_RST;
    end else begin
      if (wrControl) control_reg <= pwdata[7:0]; // [RL12]
      if (wrCommand) command_reg <= pwdata[7:0]; // [RL11]
    end
  end

  // transmit rate generator
  // it restarts on a rate change, so the first bit after a change is full
  asb_baud_gen #(
    .CLK_HZ(CLK_HZ)
  ) u_baud (
    .mclk(mclk),
    .reset(reset),
    .enable(enable),
    .baudSelect(control_reg[`ASB_BAUD_MSB:`ASB_BAUD_LSB]), // [RL12]
    .extClk(extClk),
    .bitTick(txBitTick)
  );

  // receive buffer between shifter and holding register
  // characters offered while disabled are dropped, not buffered
  // a data read blocks the move so the clear is not lost
  assign fifoInValid = rxCharValid & enable; // [RL11]
  assign rxHead = fifoOutData;
  assign rxMove = enable & ~rxFull_reg & ~rdData;

  asb_fifo #(
    .WIDTH($bits(asb_pkg::asb_rx_char_t)),
    .DEPTH(`ASB_FIFO_DEPTH)
  ) u_rxFifo (
    .mclk(mclk),
    .reset(reset),
    .inValid(fifoInValid),
    .inData(rxChar),
    .inReady(rxCharReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(rxMove)
  );

  // receive holding register and its error marks
  // the error marks always describe the character now held
  always_ff @(posedge mclk) begin
    if (reset) begin
      rxHold_reg <= 8'h00;
      rxFull_reg <= 1'b0;
      parity_reg <= 1'b0;
      framing_reg <= 1'b0;
    end else if (rxMove && fifoOutValid) begin
      rxHold_reg <= rxHead.data;
      rxFull_reg <= 1'b1; // [RL15]
      parity_reg <= rxHead.parityErr;
      framing_reg <= rxHead.framingErr; // [RL1]
    end else if (rdData) begin
      rxFull_reg <= 1'b0; // [RL15]
    end
  end

  // overrun: a character offered while the buffer is full
  // the set wins over a data read in the same cycle, so no loss goes unseen
  always_ff @(posedge mclk) begin
    if (reset) begin
      overrun_reg <= 1'b0;
    end else if (fifoInValid && !rxCharReady) begin
      overrun_reg <= 1'b1; // [RL2]
    end else if (rdData) begin
      overrun_reg <= 1'b0;
    end
  end

  // holding register moves out unless a write lands this cycle
  // a write that meets a move replaces the waiting character in the holding
  // register, so the move waits one cycle and then sends the new one
  assign txMove = enable & ~txEmpty_reg & ~wrData &
                  ((txState_reg == asb_pkg::TX_IDLE) | txCharReady);

  // transmit holding register
  always_ff @(posedge mclk) begin
    if (reset) begin
      txHold_reg <= 8'h00;
      txEmpty_reg <= 1'b1;
    end else if (wrData) begin
      txHold_reg <= pwdata[7:0];
      txEmpty_reg <= 1'b0; // [RL16]
    end else if (txMove) begin
      txEmpty_reg <= 1'b1; // [RL16]
    end
  end

  // offer stage toward the transmit shifter
  // a waiting character is loaded at the handshake edge, so the shifter
  // sees back-to-back characters without an idle cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      txState_reg <= asb_pkg::TX_IDLE;
      txCharValid <= 1'b0;
      txCharData <= 8'h00;
    end else begin
      case (txState_reg)
        asb_pkg::TX_IDLE: begin
          if (txMove) begin
            txState_reg <= asb_pkg::TX_OFFER;
            txCharValid <= 1'b1;
            txCharData <= txHold_reg;
          end
        end
        asb_pkg::TX_OFFER: begin
          if (txMove) begin
            txCharData <= txHold_reg;
          end else if (txCharReady) begin
            txState_reg <= asb_pkg::TX_IDLE;
            txCharValid <= 1'b0;
          end
        end
        default: begin
          txState_reg <= asb_pkg::TX_IDLE;
          txCharValid <= 1'b0;
        end
      endcase
    end
  end

  // modem line change detection against the held levels
  // pins are taken as synchronous, so no extra stages sit in front
  assign modemChanged = (dcdN != dcdHeld_reg) | (dsrN != dsrHeld_reg);
  assign modemEvent = enable & ~modemLock_reg & modemChanged; // [RL17]

  // held levels freeze after an interrupt until status is read
  // while disabled the held levels follow the pins, so enabling later
  // does not report an old change
  always_ff @(posedge mclk) begin
    if (reset) begin
      dcdHeld_reg <= `ASB_LINE_IDLE;
      dsrHeld_reg <= `ASB_LINE_IDLE;
      modemLock_reg <= 1'b0;
    end else if (!enable) begin
      dcdHeld_reg <= dcdN; // [RL11]
      dsrHeld_reg <= dsrN;
      modemLock_reg <= 1'b0;
    end else if (modemEvent) begin
      dcdHeld_reg <= dcdN; // [RL9]
      dsrHeld_reg <= dsrN;
      modemLock_reg <= 1'b1;
    end else if (rdStatus) begin
      modemLock_reg <= 1'b0; // [RL10]
    end
  end

  // interrupt flag: only modem events set it, set wins over read
  // receive errors and the data flags never reach this flag
  always_comb begin
    irqFlag_next = irqFlag_reg;
    if (modemEvent) begin
      irqFlag_next = 1'b1; // [RL8] [RL3]
    end else if (rdStatus) begin
      irqFlag_next = 1'b0; // [RL8]
    end
  end

  // interrupt flag and pin
  // the pin takes the next flag value so both change on one edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      irqFlag_reg <= 1'b0;
      irqN <= 1'b1;
    end else begin
      irqFlag_reg <= irqFlag_next;
      irqN <= ~irqFlag_next; // [RL18]
    end
  end

endmodule
`default_nettype wire

// ===== asb_serial_status_props.sv
`timescale 1ns/10ps
`default_nettype none
module asb_serial_status_props #(
  parameter int CLK_HZ = 100000000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // receive and transmit sides
  input wire logic rxCharValid,
  input wire asb_pkg::asb_rx_char_t rxChar,
  input wire logic rxCharReady,
  input wire logic txCharValid,
  input wire logic [7:0] txCharData,
  input wire logic txCharReady,
  input wire logic txBitTick,
  // clock, modem, interrupt
  input wire logic extClk,
  input wire logic dcdN,
  input wire logic dsrN,
  input wire logic irqN
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic enReg, codeZero, armed, extPrev;
  logic [3:0] sinceEvt, sinceRd;
  logic [5:0] extCnt;
  wire logic stRd = psel && penable && !pready && !pwrite && paddr == 12'h004;
  wire logic wrDone = psel && penable && pready && pwrite;
  wire logic rise = extClk && !extPrev;
  // shadow of enable and baud code
  always_ff @(posedge mclk) begin
    if (reset) begin
      enReg <= 1'b0;
      codeZero <= 1'b1;
    end else if (wrDone && paddr == 12'h008) begin
      enReg <= pwdata[0];
    end else if (wrDone && paddr == 12'h00c) begin
      codeZero <= pwdata[3:0] == 4'h0;
    end
  end
  // cycles since a modem change or status read
  always_ff @(posedge mclk) begin
    if (reset) begin
      sinceEvt <= 4'hf;
      sinceRd <= 4'hf;
    end else begin
      sinceEvt <= (stRd || $changed(dcdN) || $changed(dsrN)) ? 4'h0 :
                  (sinceEvt == 4'hf) ? 4'hf : sinceEvt + 4'h1;
      sinceRd <= stRd ? 4'h0 : (sinceRd == 4'hf) ? 4'hf : sinceRd + 4'h1;
    end
  end
  // external edges between ticks
  always_ff @(posedge mclk) begin
    extPrev <= extClk;
    if (reset || !enReg || (wrDone && paddr == 12'h00c)) begin
      armed <= 1'b0;
      extCnt <= 6'h0;
    end else if (txBitTick) begin
      armed <= codeZero;
      extCnt <= 6'h0;
    end else begin
      extCnt <= extCnt + {5'h0, rise};
    end
  end
  property p_apb_ans; psel && penable && !pready |=> pready; endproperty
  a_apb_ans: assert property (p_apb_ans) else $error("no answer after access");
  property p_pready_pulse; pready |=> !pready; endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");
  property p_rd_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
  property p_irq_cause; $fell(irqN) |-> sinceEvt <= 4'd6; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
  property p_irq_release; $rose(irqN) |-> sinceRd <= 4'd3; endproperty
  a_irq_release: assert property (p_irq_release) else $error("irq freed unread");
  property p_modem_irq;
    enReg && irqN && ($changed(dcdN) || $changed(dsrN)) |-> ##[1:6] !irqN;
  endproperty
  a_modem_irq: assert property (p_modem_irq) else $error("modem change ignored");
  property p_dis_quiet; !enReg && irqN |=> irqN; endproperty
  a_dis_quiet: assert property (p_dis_quiet) else $error("irq while disabled");
  property p_tx_hold; txCharValid && !txCharReady |=> txCharValid && $stable(txCharData); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx offer dropped");
  property p_ext_div; txBitTick && armed |-> extCnt + {5'h0, rise} == 6'd16; endproperty
  a_ext_div: assert property (p_ext_div) else $error("external divide wrong");
  c_irq: cover property ($fell(irqN));
  c_err: cover property (pready && pslverr);
  c_full: cover property (rxCharValid && !rxCharReady);
  c_ext: cover property (txBitTick && armed);
endmodule
bind asb_serial_status asb_serial_status_props #(.CLK_HZ(CLK_HZ)) props_u (.mclk(mclk),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxCharValid(rxCharValid), .rxChar(rxChar), .rxCharReady(rxCharReady),
  .txCharValid(txCharValid), .txCharData(txCharData), .txCharReady(txCharReady),
  .txBitTick(txBitTick), .extClk(extClk), .dcdN(dcdN), .dsrN(dsrN), .irqN(irqN));
`default_nettype wire

// ===== asb_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module asb_far_end (
  // clock
  input wire logic mclk,
  // bench requests
  input wire logic stall,
  input wire logic dcdReq,
  input wire logic dsrReq,
  // modem lines
  output logic dcdN,
  output logic dsrN,
  // transmit shifter side
  input wire logic txCharValid,
  input wire logic [7:0] txCharData,
  output logic txCharReady
);
  logic [7:0] got[$];
  initial begin
    dcdN = 1'b1;
    dsrN = 1'b1;
    txCharReady = 1'b0;
  end
  // lines follow requests, shifter takes when not stalled
  always @(posedge mclk) begin
    dcdN <= dcdReq;
    dsrN <= dsrReq;
    txCharReady <= ~stall;
    if (txCharValid && txCharReady) begin
      got.push_back(txCharData);
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rxCharValid = 1'b0, rxCharReady, txCharValid, txCharReady;
  logic txBitTick, extClk = 1'b0, stall = 1'b0, dcdReq = 1'b1, dsrReq = 1'b1;
  logic dcdN, dsrN, irqN, err;
  logic [7:0] txCharData;
  asb_pkg::asb_rx_char_t rxChar = '0;
  int err_count = 0, tests_run = 0, ph = 0;
  always #5 mclk = ~mclk;
  // external clock, four cycles a period
  always @(posedge mclk) begin
    ph <= ph + 1;
    if (ph[0]) extClk <= ~extClk;
  end
  asb_serial_status #(.CLK_HZ(150000)) dut_u (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxCharValid(rxCharValid), .rxChar(rxChar),
    .rxCharReady(rxCharReady), .txCharValid(txCharValid), .txCharData(txCharData),
    .txCharReady(txCharReady), .txBitTick(txBitTick), .extClk(extClk), .dcdN(dcdN),
    .dsrN(dsrN), .irqN(irqN));
  asb_far_end partner_u (.mclk(mclk), .stall(stall), .dcdReq(dcdReq), .dsrReq(dsrReq),
    .dcdN(dcdN), .dsrN(dsrN), .txCharValid(txCharValid), .txCharData(txCharData),
    .txCharReady(txCharReady));
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irqN !== 1'b0 && n < 10) begin
      @(posedge mclk);
      n++;
    end
    chk("irq low", 32'h0, {31'h0, irqN});
  endtask
  task automatic push(input asb_pkg::asb_rx_char_t c);
    int n;
    n = 0;
    rxChar <= c;
    rxCharValid <= 1'b1;
    @(posedge mclk);
    while (rxCharReady !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (rxCharReady !== 1'b1) err_count++;
    rxCharValid <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic gap(input logic [3:0] code, input int exp);
    int n;
    n = 0;
    apb(1'b1, 12'h00c, {28'h0, code});
    // let the first tick of the new rate, after the restart, pass
    @(posedge mclk);
    while (txBitTick !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    n = 1;
    while (txBitTick !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    chk("baud gap", exp, n);
  endtask
  task automatic t_reset;
    apb(1'b1, 12'h004, 32'hff);
    chk("status wr err", 32'h0, {31'h0, err});
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h70, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("control", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
  endtask
  task automatic t_modem;
    apb(1'b1, 12'h008, 32'h1);
    dcdReq <= 1'b0;
    wait_irq();
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'hd0, rd);
    chk("irq", 32'h1, {31'h0, irqN});
    dsrReq <= 1'b0;
    wait_irq();
    dcdReq <= 1'b1;
    repeat (4) @(posedge mclk);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h90, rd);
    wait_irq();
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'hb0, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h30, rd);
  endtask
  task automatic t_disable_tx;
    apb(1'b1, 12'h008, 32'h0);
    dsrReq <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irqN});
    stall <= 1'b1;
    apb(1'b1, 12'h000, 32'ha5);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h60, rd);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h000, 32'h3c);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h60, rd);
    stall <= 1'b0;
    repeat (8) @(posedge mclk);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h70, rd);
    chk("tx count", 32'h2, partner_u.got.size());
    chk("tx first", 32'ha5, {24'h0, partner_u.got[0]});
    chk("tx second", 32'h3c, {24'h0, partner_u.got[1]});
  endtask
  task automatic t_rx;
    for (int k = 0; k < 9; k++) begin
      push({1'b0, k == 0, 8'h10 + 8'(k)});
    end
    chk("rx ready", 32'h0, {31'h0, rxCharReady});
    // one offer into the full buffer, refused at its only edge
    rxChar <= {1'b1, 1'b0, 8'hee};
    rxCharValid <= 1'b1;
    @(posedge mclk);
    rxCharValid <= 1'b0;
    @(posedge mclk);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h7e, rd);
    chk("irq", 32'h1, {31'h0, irqN});
    apb(1'b0, 12'h000, 32'h0);
    chk("rx data", 32'h10, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h78, rd);
    for (int k = 1; k < 9; k++) begin
      apb(1'b0, 12'h000, 32'h0);
      chk("rx data", 32'h10 + k, rd);
    end
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h70, rd);
  endtask
  task automatic t_baud;
    gap(4'h1, 3000);
    gap(4'h2, 2000);
    gap(4'h0, 64);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_modem();
    t_disable_tx();
    t_rx();
    t_baud();
    print_verdict();
  end
  // hang guard
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
